// >>> core/pww_pkg.sv
// package for the supply supervisor: timing constants and state codes
// assumes a 125 MHz system clock; analog trips arrive as digital levels
package pww_pkg;
	localparam int unsigned CLK_HZ       = 125000000;
	// ----------------------------------------------------------------
	// typical times, in microseconds
	// ----------------------------------------------------------------
	localparam int unsigned T_RST_US     = 9500;
	localparam int unsigned T_DLY_US     = 16000;
	localparam int unsigned T_WDU_US     = 32000;
	localparam int unsigned T_WDL_US     = 2000;
	// ----------------------------------------------------------------
	// cycle counts: each time multiplied by the clock cycles per microsecond, no rounding
	// ----------------------------------------------------------------
	localparam int unsigned RST_CYC =
		(T_RST_US * (CLK_HZ / 1000000));
	localparam int unsigned DLY_CYC =
		(T_DLY_US * (CLK_HZ / 1000000));
	localparam int unsigned WDU_CYC =
		(T_WDU_US * (CLK_HZ / 1000000));
	localparam int unsigned WDL_CYC =
		(T_WDL_US * (CLK_HZ / 1000000));
	localparam int unsigned CNT_W        = 24;
	localparam logic [23:0] CNT_ZERO     = 24'h000000;
	localparam logic [23:0] CNT_ONE      = 24'h000001;

	typedef enum logic [2:0] {
		PWW_WD_OFF   = 3'b000,
		PWW_WD_DELAY = 3'b001,
		PWW_WD_RUN   = 3'b010,
		PWW_WD_FAULT = 3'b011
	} pww_wd_state_t;
endpackage

// >>> core/pww_por_timer.sv
// one power-on reset channel: holds reset low until the good level
// has stood for the programmed period
// assumes trip inputs are synchronous and already debounced
`timescale 1ns/1ps
module pww_por_timer
	import pww_pkg::*;
#(
	parameter logic [23:0] PERIOD = 24'h000010
) (
	// clock and reset
	input  wire logic clk_i,
	input  wire logic srst_i,
	// control
	input  wire logic active_i,
	input  wire logic good_i,
	// output
	output logic      reset_n_o
);
	logic [23:0] cnt;
	logic [23:0] next_cnt;
	logic        next_reset_n;

	always_comb begin
		next_cnt     = cnt;
		next_reset_n = reset_n_o;
		if (!active_i || !good_i) begin
			next_cnt     = CNT_ZERO;
			next_reset_n = 1'b0;
		end else if (!reset_n_o) begin
			if (cnt == PERIOD - CNT_ONE) begin
				next_reset_n = 1'b1;
			end else begin
				next_cnt = cnt + CNT_ONE;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			cnt       <= CNT_ZERO;
			reset_n_o <= 1'b0;
		end else begin
			cnt       <= next_cnt;
			reset_n_o <= next_reset_n;
		end
	end
endmodule

// >>> core/pww_supervisor.sv
// supply supervisor: two power-on reset outputs and a window watchdog
// assumes all inputs synchronous to clk_i; pins are modelled as levels
//
// Summary of operation
// - both reset outputs are low while disabled or the input supply is invalid.
// - the high channel reset releases one reset period after its trip rises.
// - the low channel reset releases one reset period after its trip rises.
// - each channel has its own reset timer and one watchdog follows the low channel only.
// - the start delay begins when the low channel reset is released.
// - window supervision begins only once the start delay has run out.
// - only falling edges of the kick input count as activity.
// - a kick too early or too late drives the fault low and starts a timer.
// - after the fault period the fault releases and a new delay begins.
// - the fault only asserts while the watchdog enable input is high.
// - one reset period serves the resets and the fault duration.
// - no kick by the upper bound is a fault.
// - a kick before the lower bound is a fault.
`timescale 1ns/1ps
module pww_supervisor
	import pww_pkg::*;
#(
	parameter logic [23:0] RST_CNT = RST_CYC[23:0],
	parameter logic [23:0] DLY_CNT = DLY_CYC[23:0],
	parameter logic [23:0] WDU_CNT = WDU_CYC[23:0],
	parameter logic [23:0] WDL_CNT = WDL_CYC[23:0]
) (
	// clock and reset
	input  wire logic clk_i,
	input  wire logic srst_i,
	// supply conditions
	input  wire logic shutdown_lockout_in_i,
	input  wire logic main_input_supply_i,
	input  wire logic hv_feedback_i,
	input  wire logic lv_feedback_i,
	// watchdog pins
	input  wire logic watchdog_enable_in_i,
	input  wire logic watchdog_kick_in_i,
	// reset and fault outputs, active low
	output logic      hv_reset_out_n_o,
	output logic      lv_reset_out_n_o,
	output logic      watchdog_fault_out_n_o
);
	import pww_pkg::*;

	// ----------------------------------------------------------------
	// power-on reset channels
	// ----------------------------------------------------------------
	logic active;
	assign active = shutdown_lockout_in_i && main_input_supply_i;

	// independent timers, one period shared by all
	pww_por_timer #(.PERIOD(RST_CNT)) u_hv (
		.clk_i     (clk_i),
		.srst_i    (srst_i),
		.active_i  (active),
		.good_i    (hv_feedback_i),
		.reset_n_o (hv_reset_out_n_o)
	);

	pww_por_timer #(.PERIOD(RST_CNT)) u_lv (
		.clk_i     (clk_i),
		.srst_i    (srst_i),
		.active_i  (active),
		.good_i    (lv_feedback_i),
		.reset_n_o (lv_reset_out_n_o)
	);

	// ----------------------------------------------------------------
	// watchdog
	// ----------------------------------------------------------------
	pww_wd_state_t state;
	pww_wd_state_t next_state;
	logic [23:0]   cnt;
	logic [23:0]   next_cnt;
	logic          kick_d;
	logic          next_fault_n;
	logic          kick_fall;

	assign kick_fall = kick_d && !watchdog_kick_in_i;

	always_comb begin
		next_state   = state;
		next_cnt     = cnt + CNT_ONE;
		next_fault_n = 1'b1;
		case (state)
			PWW_WD_OFF: begin
				next_cnt = CNT_ZERO;
				if (lv_reset_out_n_o) begin
					next_state = PWW_WD_DELAY;
				end
			end
			PWW_WD_DELAY: begin
				if (cnt == DLY_CNT - CNT_ONE) begin
					next_state = PWW_WD_RUN;
					next_cnt   = CNT_ZERO;
				end
			end
			PWW_WD_RUN: begin
				// window timed from start or last good kick
				if ((kick_fall && cnt < WDL_CNT)
				    || (!kick_fall && cnt == WDU_CNT)) begin
					if (watchdog_enable_in_i) begin
						next_state   = PWW_WD_FAULT;
						next_fault_n = 1'b0;
					end
					next_cnt = CNT_ZERO;
				end else if (kick_fall) begin
					next_cnt = CNT_ZERO;
				end
			end
			PWW_WD_FAULT: begin
				next_fault_n = 1'b0;
				if (cnt == RST_CNT - CNT_ONE) begin
					next_state   = PWW_WD_DELAY;
					next_fault_n = 1'b1;
					next_cnt     = CNT_ZERO;
				end
			end
			default: begin
				next_state = PWW_WD_OFF;
				next_cnt   = CNT_ZERO;
			end
		endcase
		// losing the low channel reset stops supervision outright
		if (!lv_reset_out_n_o) begin
			next_state   = PWW_WD_OFF;
			next_cnt     = CNT_ZERO;
			next_fault_n = 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			state                  <= PWW_WD_OFF;
			cnt                    <= CNT_ZERO;
			kick_d                 <= 1'b1;
			watchdog_fault_out_n_o <= 1'b1;
		end else begin
			state                  <= next_state;
			cnt                    <= next_cnt;
			kick_d                 <= watchdog_kick_in_i;
			watchdog_fault_out_n_o <= next_fault_n;
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	property p_rst_low_inactive;
		@(posedge clk_i) disable iff (srst_i)
		!active |=> !hv_reset_out_n_o && !lv_reset_out_n_o;
	endproperty
	a_rst_low_inactive: assert property (p_rst_low_inactive)
		else $error("reset released while inactive");

	property p_hv_needs_good;
		@(posedge clk_i) disable iff (srst_i)
		$rose(hv_reset_out_n_o) |-> $past(hv_feedback_i) && $past(active);
	endproperty
	a_hv_needs_good: assert property (p_hv_needs_good)
		else $error("high reset released without good trip");

	property p_lv_hold;
		@(posedge clk_i) disable iff (srst_i)
		$rose(lv_feedback_i) && active |=> !lv_reset_out_n_o [*8];
	endproperty
	a_lv_hold: assert property (p_lv_hold)
		else $error("low reset released too early");

	property p_delay_starts;
		@(posedge clk_i) disable iff (srst_i)
		$rose(lv_reset_out_n_o) |=> state == PWW_WD_DELAY;
	endproperty
	a_delay_starts: assert property (p_delay_starts)
		else $error("start delay not begun");

	property p_no_fault_early;
		@(posedge clk_i) disable iff (srst_i)
		state == PWW_WD_DELAY |=> watchdog_fault_out_n_o;
	endproperty
	a_no_fault_early: assert property (p_no_fault_early)
		else $error("fault during start delay");

	property p_fast_kick;
		@(posedge clk_i) disable iff (srst_i)
		state == PWW_WD_RUN && kick_fall && cnt < WDL_CNT
		&& watchdog_enable_in_i && lv_reset_out_n_o
		|=> !watchdog_fault_out_n_o;
	endproperty
	a_fast_kick: assert property (p_fast_kick)
		else $error("early kick not flagged");

	property p_fault_enable;
		@(posedge clk_i) disable iff (srst_i)
		$fell(watchdog_fault_out_n_o) |-> $past(watchdog_enable_in_i);
	endproperty
	a_fault_enable: assert property (p_fault_enable)
		else $error("fault while watchdog disabled");

	property p_fault_end;
		@(posedge clk_i) disable iff (srst_i)
		$rose(watchdog_fault_out_n_o) && lv_reset_out_n_o
		|-> state == PWW_WD_DELAY;
	endproperty
	a_fault_end: assert property (p_fault_end)
		else $error("no fresh delay after fault");

	property p_late_kick;
		@(posedge clk_i) disable iff (srst_i)
		state == PWW_WD_RUN && !kick_fall && cnt == WDU_CNT
		&& watchdog_enable_in_i && lv_reset_out_n_o
		|=> !watchdog_fault_out_n_o;
	endproperty
	a_late_kick: assert property (p_late_kick)
		else $error("missing kick not flagged");

	// an accepted kick must open a fresh window, not carry the old count
	property p_kick_restart;
		@(posedge clk_i) disable iff (srst_i)
		state == PWW_WD_RUN && kick_fall && cnt >= WDL_CNT
		&& lv_reset_out_n_o
		|=> state == PWW_WD_RUN && cnt == CNT_ZERO;
	endproperty
	a_kick_restart: assert property (p_kick_restart)
		else $error("accepted kick did not restart window");

	c_fault: cover property (@(posedge clk_i) $fell(watchdog_fault_out_n_o));
	c_run: cover property (@(posedge clk_i) state == PWW_WD_RUN && kick_fall);
	c_hv: cover property (@(posedge clk_i) $rose(hv_reset_out_n_o));
endmodule

// >>> dv/pww_kick_model.sv
// partner model: the supervised processor kicking the watchdog pin
// assumes it only runs while the low channel reset is released
`timescale 1ns/1ps
module pww_kick_model (
	// clock and control
	input  wire logic       clk_i,
	input  wire logic       run_i,
	input  wire logic [7:0] period_i,
	// kick pin
	output logic            kick_o
);
	int cnt;
	initial begin
		cnt = 0;
		kick_o = 1'b1;
	end
	// two-cycle low pulses keep both pin pulse widths legal
	always @(negedge clk_i) begin
		if (!run_i || period_i == 8'h00) begin
			cnt = 0;
			kick_o = 1'b1;
		end else begin
			cnt = (cnt + 1) % int'(period_i);
			kick_o = (cnt >= 2);
		end
	end
endmodule

// >>> dv/pww_supervisor_tb.sv
// bench for the supply supervisor: supply table, then watchdog cases
// assumes shortened counts; the partner model drives the kick pin
`timescale 1ns/1ps
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin \
	miscompares++; $display("Error %s exp %0h got %0h", n, e, s); end end
module pww_supervisor_tb;
	import pww_pkg::*;
	localparam logic [23:0] R = 24'h000014;
	localparam logic [23:0] D = 24'h00001E;
	localparam logic [23:0] U = 24'h00003C;
	localparam logic [23:0] L = 24'h00000A;
	// {enable, supply, hv good, lv good, hv reset_n, lv reset_n}
	logic [5:0] rows [6] = '{6'h3F, 6'h1C, 6'h2C, 6'h35, 6'h3A, 6'h30};
	logic       clk_i = 1'b0;
	logic       srst_i = 1'b1;
	logic       lock, sup, hv, lv, watchdog_enable_in;
	logic [7:0] per;
	logic       kick, hv_n, lv_n, flt_n;
	int         miscompares, total_checks, lows, c;

	always #4 clk_i = ~clk_i;
	always @(posedge clk_i) if (flt_n === 1'b0) lows++;

	pww_supervisor #(.RST_CNT(R), .DLY_CNT(D), .WDU_CNT(U), .WDL_CNT(L))
	i_dut (
		.clk_i                 (clk_i),
		.srst_i                (srst_i),
		.shutdown_lockout_in_i (lock),
		.main_input_supply_i   (sup),
		.hv_feedback_i         (hv),
		.lv_feedback_i         (lv),
		.watchdog_enable_in_i  (watchdog_enable_in),
		.watchdog_kick_in_i    (kick),
		.hv_reset_out_n_o      (hv_n),
		.lv_reset_out_n_o      (lv_n),
		.watchdog_fault_out_n_o(flt_n)
	);
	pww_kick_model i_mcu (
		.clk_i   (clk_i),
		.run_i   (lv_n),
		.period_i(per),
		.kick_o  (kick)
	);

	task automatic stop_test;
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// bounded wait for a reset output to rise after its trip goes high
	task automatic lat(input bit is_hv);
		c = 0;
		if (is_hv) hv = 1'b1;
		else lv = 1'b1;
		while ((is_hv ? hv_n : lv_n) !== 1'b1 && c < 200) begin
			@(negedge clk_i);
			c++;
		end
	endtask
	task automatic wait_fault;
		c = 0;
		lows = 0;
		while (lows == 0 && c < 400) begin
			@(negedge clk_i);
			c++;
		end
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		{lock, sup, hv, lv, watchdog_enable_in, per} = {5'b11000, 8'h00};
		repeat (16) @(posedge clk_i);
		@(negedge clk_i) srst_i = 1'b0;
		`CHK("hv_n", 1'b0, hv_n)
		`CHK("lv_n", 1'b0, lv_n)
		`CHK("flt_n", 1'b1, flt_n)
		foreach (rows[i]) begin
			{lock, sup, hv, lv} = rows[i][5:2];
			repeat (R + 4) @(negedge clk_i);
			`CHK("resets", rows[i][1:0], {hv_n, lv_n})
		end
		$display("supply table done");
		{hv, lv, watchdog_enable_in, per} = {3'b001, 8'h04};
		repeat (R + 4) @(negedge clk_i);
		lat(1'b1);
		`CHK("hv delay", 1'b1, (c >= R && c <= R + 2))
		`CHK("lv_n held", 1'b0, lv_n)
		lat(1'b0);
		`CHK("lv delay", 1'b1, (c >= R && c <= R + 2))
		$display("reset timing done");
		wait_fault;
		`CHK("early kick", 1'b1, (c >= D && c <= D + 8))
		wait (flt_n === 1'b1);
		`CHK("fault width", R, 24'(lows))
		wait_fault;
		`CHK("new delay", 1'b1, (c >= D && c <= D + 8))
		@(posedge flt_n);
		// nonblocking so the model, which also runs on this edge, sees
		// the old period and no race decides the phase
		@(negedge clk_i) per <= 8'h19;
		lows = 0;
		repeat (300) @(negedge clk_i);
		`CHK("good kicks", 0, lows)
		per <= 8'h00;
		wait_fault;
		`CHK("late kick", 1'b1, (c >= U - 26 && c <= U + 4))
		@(posedge flt_n);
		@(negedge clk_i) watchdog_enable_in = 1'b0;
		lows = 0;
		repeat (200) @(negedge clk_i);
		`CHK("disabled", 0, lows)
		`CHK("flt_n off", 1'b1, flt_n)
		$display("watchdog cases done");
		// reset in mid-run with every trip still good
		srst_i = 1'b1;
		repeat (2) @(negedge clk_i);
		`CHK("rst hv_n", 1'b0, hv_n)
		`CHK("rst lv_n", 1'b0, lv_n)
		`CHK("rst flt_n", 1'b1, flt_n)
		srst_i = 1'b0;
		lat(1'b0);
		`CHK("lv after rst", 1'b1, (c >= R && c <= R + 2))
		`CHK("hv after rst", 1'b1, hv_n)
		$display("mid-run reset done");
		stop_test;
	end

	initial begin
		repeat (3000) @(posedge clk_i);
		miscompares++;
		$display("Error run did not finish in time");
		stop_test;
	end
endmodule
